// File: rtl/mscif_pkg.sv
// Package for the mux switch control interface.
// Assumes a single 250 MHz core clock domain; all pins arrive asynchronous.
package mscif_pkg;
  localparam int unsigned SHIFT_BITS  = 4;
  localparam int unsigned NUM_INPUTS  = 8;
  localparam int unsigned SYNC_STAGES = 2;
  // Control word field positions, first bit in time is the low one
  localparam int unsigned SEL_LOW_POS  = 0;
  localparam int unsigned SEL_MID_POS  = 1;
  localparam int unsigned SEL_HIGH_POS = 2;
  localparam int unsigned DISABLE_POS  = 3;
  // Power-on values
  localparam logic [2:0] SEL_RESET     = 3'h0;
  localparam logic       DISABLE_RESET = 1'h1;
  localparam logic       ALLOW_RESET   = 1'h0;
  localparam logic [3:0] SHIFT_RESET   = 4'h0;
  localparam logic [7:0] SWITCH_OPEN   = 8'h00;
endpackage : mscif_pkg

// File: rtl/mscif_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pins.
// Assumes the pins are quasi-static relative to mclk or edge-detected downstream.
`timescale 1ns/1ps
`default_nettype none
module mscif_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  // Pins in, synchronised out
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } mscif_sync_t;

  mscif_sync_t s_q;
  mscif_sync_t s_d;

  // First stage feeds only the second stage
  always_comb begin
    s_d        = s_q;
    s_d.meta   = async_in;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stable;
endmodule : mscif_sync
`default_nettype wire

// File: rtl/mscif_top.sv
// Digital control front end of a dual analog multiplexer.
// Assumes every pin is asynchronous to mclk; shift clock is sampled, not used as a clock.
`timescale 1ns/1ps
`default_nettype none
module mscif_top (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // Host pins
  input  wire logic       interface_select,
  input  wire logic       clear_n,
  input  wire logic       transparent_latch_n,
  input  wire logic       select_bit_high,
  input  wire logic       select_bit_mid,
  input  wire logic       select_bit_low_in,
  input  wire logic       channel_allow,
  input  wire logic       pair_mode,
  // Cascade output shares the low select pin
  output logic            select_bit_low_out,
  output logic            select_bit_low_oe_n,
  // Switch closures: bits 0..3 to first common terminal, 4..7 to second
  output logic [7:0]      switch_closed,
  output logic [2:0]      latched_select,
  output logic            latched_disable
);
  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int unsigned NPIN = 8;
  logic [NPIN-1:0] pins_s;

  mscif_sync #(.W(NPIN)) u_sync (
    .mclk     (mclk),
    .rstn     (rstn),
    .async_in ({interface_select, clear_n, transparent_latch_n, select_bit_high,
                select_bit_mid, select_bit_low_in, channel_allow, pair_mode}),
    .sync_out (pins_s)
  );

  logic ser_s, clr_n_s, le_n_s, sclk_s, din_s, a0_s, allow_s, pair_s;
  assign {ser_s, clr_n_s, le_n_s, sclk_s, din_s, a0_s, allow_s, pair_s} = pins_s;
  // In serial mode the high select pin is the shift clock, mid is data,
  // and the latch enable pin is the chip select

  //////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [3:0] shift;
    logic       sclk_prev;
    logic       cs_prev;
    logic [2:0] sel;
    logic       dis;
    logic       allow;
    logic       dout;
    logic [7:0] sw;
  } mscif_state_t;

  mscif_state_t st_q;
  mscif_state_t st_d;
  logic [7:0]   dec;

  // Next state first, then the decoder from the new latch word in the same pass
  always_comb begin
    dec            = mscif_pkg::SWITCH_OPEN;
    st_d           = st_q;
    st_d.sclk_prev = sclk_s;
    st_d.cs_prev   = le_n_s;
    if (!clr_n_s) begin
      st_d.shift = mscif_pkg::SHIFT_RESET;
      st_d.sel   = mscif_pkg::SEL_RESET;
      st_d.dis   = mscif_pkg::DISABLE_RESET;
      st_d.allow = mscif_pkg::ALLOW_RESET;
      st_d.dout  = 1'b0;
      // Sync flops clear low; idle high here keeps a false select rise away
      st_d.cs_prev = 1'b1;
    end else if (ser_s) begin
      // Shift only while selected; new bit enters stage 0
      if (!le_n_s && sclk_s && !st_q.sclk_prev) begin
        st_d.shift = {st_q.shift[2:0], din_s};
        // Cascade shows the new fourth stage, so a chained part sees 4 bits
        st_d.dout  = st_q.shift[2];
      end
      // Last bit in time lands in the disable position
      if (le_n_s && !st_q.cs_prev) begin
        st_d.sel[0] = st_q.shift[mscif_pkg::SEL_LOW_POS + 3];
        st_d.sel[1] = st_q.shift[mscif_pkg::SEL_MID_POS + 1];
        st_d.sel[2] = st_q.shift[mscif_pkg::SEL_HIGH_POS - 1];
        st_d.dis    = st_q.shift[mscif_pkg::DISABLE_POS - 3];
        st_d.allow  = 1'b1;
      end
    end else begin
      if (!le_n_s) begin
        st_d.sel   = {sclk_s, din_s, a0_s};
        st_d.dis   = 1'b0;
        st_d.allow = allow_s;
      end
    end
    // Pair mode read live, never stored
    if (!st_d.dis) begin
      if (pair_s) begin
        dec[{1'b0, st_d.sel[1:0]}] = 1'b1;
        dec[{1'b1, st_d.sel[1:0]}] = 1'b1;
      end else begin
        dec[st_d.sel] = 1'b1;
      end
    end
    // Serial: live allow pin overrides; parallel: latched allow
    if (ser_s ? !allow_s : !st_d.allow) begin
      dec = mscif_pkg::SWITCH_OPEN;
    end
    st_d.sw = dec;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q.shift     <= mscif_pkg::SHIFT_RESET;
      st_q.sclk_prev <= 1'b0;
      st_q.cs_prev   <= 1'b1;
      st_q.sel       <= mscif_pkg::SEL_RESET;
      st_q.dis       <= mscif_pkg::DISABLE_RESET;
      st_q.allow     <= mscif_pkg::ALLOW_RESET;
      st_q.dout      <= 1'b0;
      st_q.sw        <= mscif_pkg::SWITCH_OPEN;
    end else begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign select_bit_low_out  = st_q.dout;
  assign select_bit_low_oe_n = ~ser_s;
  assign switch_closed       = st_q.sw;
  assign latched_select      = st_q.sel;
  assign latched_disable     = st_q.dis;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_reset_opens_all: assert property (@(posedge mclk) disable iff (!rstn)
    !clr_n_s |=> (st_q.sw == 8'h00) && st_q.dis && (st_q.sel == 3'h0))
    else $error("clear did not open switches");
  chk_dis_opens: assert property (@(posedge mclk) disable iff (!rstn)
    st_q.dis |-> st_q.sw == 8'h00)
    else $error("disable left a switch closed");
  chk_shift_on_edge: assert property (@(posedge mclk) disable iff (!rstn)
    (clr_n_s && ser_s && !le_n_s && sclk_s && !st_q.sclk_prev)
      |=> st_q.shift == {$past(st_q.shift[2:0]), $past(din_s)})
    else $error("shift register missed a bit");
  chk_cascade_stage: assert property (@(posedge mclk) disable iff (!rstn)
    st_q.dout == st_q.shift[3])
    else $error("cascade is not the last stage");
  // Qualify by the clear seen when the change was made, not the one now
  chk_dout_only_on_edge: assert property (@(posedge mclk) disable iff (!rstn)
    $changed(st_q.dout) && $past(clr_n_s) |-> $past(sclk_s) && !$past(st_q.sclk_prev))
    else $error("cascade output moved without clock");
  // First bit in time sits in the last stage when select rises
  chk_load_on_cs: assert property (@(posedge mclk) disable iff (!rstn)
    (clr_n_s && ser_s && le_n_s && !st_q.cs_prev)
      |=> {st_q.sel[0], st_q.sel[1], st_q.sel[2], st_q.dis} == $past(st_q.shift))
    else $error("latch load mismatch");
  chk_hold_no_cs: assert property (@(posedge mclk) disable iff (!rstn)
    (clr_n_s && ser_s && !(le_n_s && !st_q.cs_prev)) |=> $stable(st_q.sel))
    else $error("latch changed without select rise");
  chk_allow_low: assert property (@(posedge mclk) disable iff (!rstn)
    (ser_s && !allow_s) |=> st_q.sw == 8'h00)
    else $error("allow low left a switch closed");
  chk_par_latch: assert property (@(posedge mclk) disable iff (!rstn)
    (clr_n_s && !ser_s && !le_n_s) |=> st_q.sel == $past({sclk_s, din_s, a0_s}))
    else $error("transparent latch failed");
  chk_par_hold: assert property (@(posedge mclk) disable iff (!rstn)
    (clr_n_s && !ser_s && le_n_s) |=> $stable(st_q.sel))
    else $error("held latch changed");
  chk_oe_par: assert property (@(posedge mclk) disable iff (!rstn)
    !ser_s |-> select_bit_low_oe_n)
    else $error("cascade driven in parallel mode");
  chk_par_idle: assert property (@(posedge mclk) disable iff (!rstn)
    (clr_n_s && !ser_s) |=> $stable(st_q.shift) && $stable(st_q.dout))
    else $error("shifter moved in parallel mode");
  chk_one_hot: assert property (@(posedge mclk) disable iff (!rstn)
    (!st_d.dis && !pair_s && (ser_s ? allow_s : st_d.allow)) |=> $onehot(st_q.sw))
    else $error("single mode not one-hot");
  cov_serial_load: cover property (@(posedge mclk) ser_s && le_n_s && !st_q.cs_prev);
  cov_pair_mode:   cover property (@(posedge mclk) pair_s && st_q.sw != 8'h00);
  cov_parallel:    cover property (@(posedge mclk) !ser_s && st_q.sw != 8'h00);
endmodule : mscif_top
`default_nettype wire

// File: test/mscif_host_model.sv
// Host model: drives the mux interface pins in parallel or serial mode.
// Assumes pins change only at falling mclk; the shift clock idles low.
`timescale 1ns/1ps
`default_nettype none
module mscif_host_model (
  // Clock
  input  wire logic mclk,
  // Pins to the device
  output var  logic interface_select,
  output var  logic transparent_latch_n,
  output var  logic select_bit_high,
  output var  logic select_bit_mid,
  output var  logic select_bit_low_in,
  output var  logic channel_allow,
  output var  logic pair_mode
);
  initial begin
    {interface_select, select_bit_high, select_bit_mid, select_bit_low_in} = 4'h0;
    {transparent_latch_n, channel_allow, pair_mode} = 3'h4;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask : wait_n
  task automatic pins(input logic le_n, a);
    transparent_latch_n = le_n;
    channel_allow = a;
  endtask : pins
  // Le_n high moves the pins but leaves the latches holding
  task automatic par(input logic [2:0] s, input logic a, p, le_n);
    interface_select = 1'h0;
    {select_bit_high, select_bit_mid, select_bit_low_in} = s;
    pair_mode = p;
    pins(le_n, a);
    wait_n(8);
    transparent_latch_n = 1'h1;
  endtask : par
  // Chip select left low; the caller raises it to load
  task automatic ser_shift(input logic [3:0] w, input logic p);
    select_bit_high = 1'h0;
    interface_select = 1'h1;
    pair_mode = p;
    select_bit_low_in = ~select_bit_low_in;
    pins(1'h0, 1'h1);
    for (int i = 0; i < 4; i++) begin
      select_bit_mid = w[i];
      wait_n(20);
      select_bit_high = 1'h1;
      wait_n(20);
      select_bit_high = 1'h0;
    end
    // Data line is no longer held; never leave the old bit showing
    select_bit_mid = ~w[3];
  endtask : ser_shift
endmodule : mscif_host_model
`default_nettype wire

// File: test/tb_top.sv
// Bench for the mux switch control interface: host model drives, monitor compares.
// Assumes outputs settle within 8 mclk of any pin change.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk, rstn, clear_n, interface_select, transparent_latch_n, select_bit_high;
  logic select_bit_mid, select_bit_low_in, channel_allow, pair_mode;
  logic select_bit_low_out, select_bit_low_oe_n, latched_disable;
  logic [7:0] switch_closed;
  logic [2:0] latched_select;
  logic [11:0] exp_q[$];
  logic [11:0] last;
  logic [3:0] w;
  logic [31:0] r;
  int bad_count, n_tests, seed;
  event chk_ev;
  mscif_host_model mscif_host_model_inst (.mclk, .interface_select, .transparent_latch_n,
    .select_bit_high, .select_bit_mid, .select_bit_low_in, .channel_allow, .pair_mode);
  mscif_top mscif_top_inst (.mclk, .rstn, .interface_select, .clear_n, .transparent_latch_n,
    .select_bit_high, .select_bit_mid, .select_bit_low_in, .channel_allow, .pair_mode,
    .select_bit_low_out, .select_bit_low_oe_n, .switch_closed, .latched_select,
    .latched_disable);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] dec(input logic [2:0] s, input logic d, a, p);
    if (d || !a) return 8'h00;
    if (p) return 8'h11 << s[1:0];
    return 8'h01 << s;
  endfunction : dec
  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic chk_state(input logic [11:0] e);
    n_tests++;
    if ({switch_closed, latched_select, latched_disable} !== e) begin
      bad_count++;
      $display("[FAIL] state exp %h got %h", e, {switch_closed, latched_select,
        latched_disable});
    end
  endtask : chk_state
  task automatic chk_bit(input string nm, input logic e, g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %b got %b", nm, e, g);
    end
  endtask : chk_bit
  // Note the result, let the pin syncs settle, then wake the monitor
  task automatic expect_state(input logic [11:0] e);
    exp_q.push_back(e);
    last = e;
    mscif_host_model_inst.wait_n(8);
    ->chk_ev;
    mscif_host_model_inst.wait_n(1);
  endtask : expect_state
  always @(chk_ev) chk_state(exp_q.pop_front());
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h7b14;
    bad_count = 0;
    n_tests = 0;
    rstn = 1'h0;
    clear_n = 1'h1;
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    rstn = 1'h1;
    expect_state({8'h00, 3'h0, 1'h1});
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      mscif_host_model_inst.par(r[2:0], i != 3, i > 7, 1'h0);
      expect_state({dec(r[2:0], 1'h0, i != 3, i > 7), r[2:0], 1'h0});
    end
    // Latch held: new selects ignored, pair mode still acts live
    mscif_host_model_inst.par(~r[2:0], 1'h0, 1'h0, 1'h1);
    expect_state({dec(r[2:0], 1'h0, 1'h1, 1'h0), r[2:0], 1'h0});
    chk_bit("cascade_oe_n", 1'h1, select_bit_low_oe_n);
    $display("parallel test done");
    for (int i = 0; i < 17; i++) begin
      r = $random(seed);
      w = i[3:0] | {4{i == 16}};
      mscif_host_model_inst.ser_shift(w, r[0]);
      expect_state({dec(last[3:1], last[0], 1'h1, r[0]), last[3:0]});
      mscif_host_model_inst.pins(1'h1, 1'h1);
      expect_state({dec(w[2:0], w[3], 1'h1, r[0]), w[2:0], w[3]});
      chk_bit("cascade", w[0], select_bit_low_out);
      chk_bit("cascade_oe_n", 1'h0, select_bit_low_oe_n);
    end
    mscif_host_model_inst.ser_shift(4'h7, 1'h0);
    mscif_host_model_inst.pins(1'h1, 1'h1);
    expect_state({8'h80, 3'h7, 1'h0});
    mscif_host_model_inst.pins(1'h1, 1'h0);
    expect_state({8'h00, 3'h7, 1'h0});
    $display("serial test done");
    clear_n = 1'h0;
    expect_state({8'h00, 3'h0, 1'h1});
    chk_bit("cascade", 1'h0, select_bit_low_out);
    clear_n = 1'h1;
    $display("clear test done");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
